//--- hw/lamp_ctrl_pkg.sv
// constants, register map and timing counts for the lamp brightness control
// assumes a single 200 MHz clock and an Avalon-MM register slave
package lamp_ctrl_pkg;

    // ----------------------------------------
    // clock and timing
    // ----------------------------------------
    localparam int CLK_HZ       = 200_000_000;
    localparam int OSC_FAST_HZ  = 290_000;
    localparam int OSC_SLOW_HZ  = 145_000;
    localparam int CHOP_HZ      = 280;
    localparam int OSC_FAST_CYC = CLK_HZ / OSC_FAST_HZ;
    localparam int OSC_SLOW_CYC = CLK_HZ / OSC_SLOW_HZ;
    localparam int CHOP_CYC     = CLK_HZ / CHOP_HZ;

    // ----------------------------------------
    // widths
    // ----------------------------------------
    localparam int LEVEL_W = 5;
    localparam int OSC_W   = 11;
    localparam int CHOP_W  = 20;
    localparam int ADDR_W  = 4;
    localparam int DATA_W  = 32;

    // ----------------------------------------
    // brightness levels
    // ----------------------------------------
    localparam logic [LEVEL_W-1:0] LEVEL_MID = 5'h10;
    localparam logic [LEVEL_W-1:0] LEVEL_MAX = 5'h1f;
    localparam logic [LEVEL_W-1:0] LEVEL_MIN = 5'h00;
    localparam logic [LEVEL_W-1:0] LEVEL_ONE = 5'h01;

    // ----------------------------------------
    // register byte offsets
    // ----------------------------------------
    localparam logic [ADDR_W-1:0] OFS_CTRL   = 4'h0;
    localparam logic [ADDR_W-1:0] OFS_CFG_A  = 4'h4;
    localparam logic [ADDR_W-1:0] OFS_CFG_B  = 4'h8;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 4'hc;

    // ----------------------------------------
    // field positions
    // ----------------------------------------
    localparam int CTRL_SERIAL_BIT = 0;
    localparam int STAT_COUNT_LSB  = 0;
    localparam int STAT_DAC_LSB    = 8;
    localparam int STAT_LOW_POWER_OFF_N_BIT   = 16;
    localparam int STAT_CHOP_BIT   = 17;
    localparam int STAT_SW_BIT     = 18;
    localparam int STAT_SUSP_BIT   = 19;

    // ----------------------------------------
    // reset values
    // ----------------------------------------
    localparam logic                CTRL_SERIAL_RST = 1'b0;
    localparam logic [LEVEL_W-1:0]  CFG_RST         = 5'h10;

endpackage

//--- hw/lamp_brightness_updown_ctrl.sv
// digital core of a cold-cathode lamp driver: up/down brightness counter,
// switching oscillator, low-rate current chopping and switch gating
// assumes pin inputs synchronous to mclk_i and comparators outside as levels
//
// How it works
// R01 - increment rising edge adds one to count
// R02 - decrement rising edge subtracts one from count
// R03 - both inputs high load mid-scale
// R04 - host holds pulses high and low 1 us
// R05 - host spaces increment and decrement by 1 us
// R06 - shutdown low stops switch, low power
// R07 - suspend input picks one of two configs
// R08 - oscillator 290 kHz at reference, else 145
// R09 - floor input at supply chops at 280 Hz
// R10 - open tube above reference forces switch off
// R11 - lamp off discharges soft-start node
// R12 - current above limit ends switch cycle
// R13 - power-up counter value is mid-scale 10000
// R14 - counter saturates at 0 and 31
// R15 - counter keeps value and counts in shutdown
//
// The address map and the Avalon-MM interface to the registers were decided locally.
`timescale 1ns/1ps

module lamp_brightness_updown_ctrl #(
    parameter int CHOP_CYC = lamp_ctrl_pkg::CHOP_CYC
) (
    // clock and reset
    input  wire logic        mclk_i,
    input  wire logic        rst_n_i,
    // brightness pulses from host
    input  wire logic        increment_pulse_i,
    input  wire logic        decrement_pulse_i,
    // pin-level controls and comparator results
    input  wire logic        low_power_off_n_i,
    input  wire logic        suspend_config_select_i,
    input  wire logic        sync_at_ref_i,
    input  wire logic        floor_level_in_i,
    input  wire logic        open_tube_above_ref_i,
    input  wire logic        cs_above_loop_limit_i,
    // lamp drive
    output logic [4:0]       dac_code_o,
    output logic             power_switch_o,
    output logic             ss_discharge_o,
    // avalon-mm register slave
    input  wire logic [3:0]  address_i,
    input  wire logic        read_i,
    input  wire logic        write_i,
    input  wire logic [31:0] writedata_i,
    input  wire logic [3:0]  byteenable_i,
    output logic [31:0]      readdata_o,
    output logic             waitrequest_o
);

    // ----------------------------------------
    // state
    // ----------------------------------------
    typedef struct packed {
        logic [4:0]  count;
        logic        inc_prev;
        logic        dec_prev;
        logic [4:0]  dac;
        logic [10:0] osc;
        logic        sw_on;
        logic [19:0] chop;
        logic        chop_on;
        logic        ss_dis;
        logic        serial_mode;
        logic [4:0]  cfg_a;
        logic [4:0]  cfg_b;
        logic        waitreq;
        logic [31:0] rdata;
    } state_t;

    localparam state_t STATE_RST = '{
        count:       lamp_ctrl_pkg::LEVEL_MID,
        inc_prev:    1'b0,
        dec_prev:    1'b0,
        dac:         lamp_ctrl_pkg::LEVEL_MID,
        osc:         11'h000,
        sw_on:       1'b0,
        chop:        20'h00000,
        chop_on:     1'b1,
        ss_dis:      1'b1,
        serial_mode: lamp_ctrl_pkg::CTRL_SERIAL_RST,
        cfg_a:       lamp_ctrl_pkg::CFG_RST,
        cfg_b:       lamp_ctrl_pkg::CFG_RST,
        waitreq:     1'b1,
        rdata:       32'h0000_0000
    };

    localparam logic [10:0] OSC_FAST_LAST = 11'(lamp_ctrl_pkg::OSC_FAST_CYC - 1);
    localparam logic [10:0] OSC_SLOW_LAST = 11'(lamp_ctrl_pkg::OSC_SLOW_CYC - 1);
    localparam logic [19:0] CHOP_LAST     = 20'(CHOP_CYC - 1);

    state_t st_r;
    state_t st_nxt;

    // ----------------------------------------
    // register read decode
    // ----------------------------------------
    function automatic logic [31:0] reg_read(input state_t s, input logic [3:0] a, input logic low_power_off_n_n,
                                             input logic floor, input logic susp);
        logic [31:0] d;
        d = 32'h0000_0000;
        unique case (a)
            lamp_ctrl_pkg::OFS_CTRL:   d[lamp_ctrl_pkg::CTRL_SERIAL_BIT] = s.serial_mode;
            lamp_ctrl_pkg::OFS_CFG_A:  d[4:0] = s.cfg_a;
            lamp_ctrl_pkg::OFS_CFG_B:  d[4:0] = s.cfg_b;
            lamp_ctrl_pkg::OFS_STATUS: begin
                d[lamp_ctrl_pkg::STAT_COUNT_LSB +: 5] = s.count;
                d[lamp_ctrl_pkg::STAT_DAC_LSB +: 5]   = s.dac;
                d[lamp_ctrl_pkg::STAT_LOW_POWER_OFF_N_BIT]       = ~low_power_off_n_n;
                d[lamp_ctrl_pkg::STAT_CHOP_BIT]       = floor;
                d[lamp_ctrl_pkg::STAT_SW_BIT]         = s.sw_on;
                d[lamp_ctrl_pkg::STAT_SUSP_BIT]       = susp;
            end
            default:                   d = 32'h0000_0000;
        endcase
        return d;
    endfunction

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        logic        inc_rise;
        logic        dec_rise;
        logic        lamp_en;
        logic [10:0] osc_last;
        logic [25:0] chop_lim;
        inc_rise = 1'b0;
        dec_rise = 1'b0;
        lamp_en  = 1'b0;
        osc_last = 11'h000;
        chop_lim = 26'h0000000;
        st_nxt   = st_r;

        // R04 one-cycle edge detect
        inc_rise = increment_pulse_i & ~st_r.inc_prev;
        dec_rise = decrement_pulse_i & ~st_r.dec_prev;
        st_nxt.inc_prev = increment_pulse_i;
        st_nxt.dec_prev = decrement_pulse_i;

        // R15 counts regardless of shutdown
        if (increment_pulse_i && decrement_pulse_i) begin
            // R03 both high preset
            st_nxt.count = lamp_ctrl_pkg::LEVEL_MID;
        end else if (inc_rise && st_r.count != lamp_ctrl_pkg::LEVEL_MAX) begin
            // R01 R14 saturating increment
            st_nxt.count = st_r.count + lamp_ctrl_pkg::LEVEL_ONE;
        end else if (dec_rise && st_r.count != lamp_ctrl_pkg::LEVEL_MIN) begin
            // R02 R14 saturating decrement
            st_nxt.count = st_r.count - lamp_ctrl_pkg::LEVEL_ONE;
        end

        // R07 serial mode config select
        if (st_r.serial_mode) begin
            st_nxt.dac = suspend_config_select_i ? st_r.cfg_b : st_r.cfg_a;
        end else begin
            st_nxt.dac = st_r.count;
        end

        // R09 low-rate chopping counter
        chop_lim = 26'((27'(st_r.dac) + 27'h1) * 27'(CHOP_CYC)) >> 5;
        if (floor_level_in_i) begin
            st_nxt.chop    = (st_r.chop == CHOP_LAST) ? 20'h00000 : st_r.chop + 20'h00001;
            st_nxt.chop_on = 26'(st_r.chop) < chop_lim;
        end else begin
            st_nxt.chop    = 20'h00000;
            st_nxt.chop_on = 1'b1;
        end

        // R08 oscillator period select
        osc_last = sync_at_ref_i ? OSC_FAST_LAST : OSC_SLOW_LAST;
        st_nxt.osc = (st_r.osc >= osc_last) ? 11'h000 : st_r.osc + 11'h001;

        // R06 R10 lamp enable gating
        lamp_en = low_power_off_n_i & ~open_tube_above_ref_i & st_r.chop_on;
        if (!lamp_en || cs_above_loop_limit_i) begin
            // R12 cycle ends on overcurrent
            st_nxt.sw_on = 1'b0;
        end else if (st_r.osc >= osc_last) begin
            st_nxt.sw_on = 1'b1;
        end

        // R11 soft-start discharge when off
        st_nxt.ss_dis = ~low_power_off_n_i;

        // avalon slave, one wait cycle
        if (st_r.waitreq) begin
            if (read_i || write_i) begin
                st_nxt.waitreq = 1'b0;
                st_nxt.rdata   = read_i ? reg_read(st_r, address_i, low_power_off_n_i, floor_level_in_i,
                                                   suspend_config_select_i) : 32'h0000_0000;
            end
        end else begin
            st_nxt.waitreq = 1'b1;
            if (write_i && byteenable_i[0]) begin
                unique case (address_i)
                    lamp_ctrl_pkg::OFS_CTRL:  st_nxt.serial_mode = writedata_i[lamp_ctrl_pkg::CTRL_SERIAL_BIT];
                    lamp_ctrl_pkg::OFS_CFG_A: st_nxt.cfg_a = writedata_i[4:0];
                    lamp_ctrl_pkg::OFS_CFG_B: st_nxt.cfg_b = writedata_i[4:0];
                    default:                  st_nxt.rdata = st_r.rdata;
                endcase
            end
        end
    end

    // ----------------------------------------
    // registers
    // ----------------------------------------
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            // R13 mid-scale at power-up
            st_r <= STATE_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign dac_code_o     = st_r.dac;
    assign power_switch_o = st_r.sw_on;
    assign ss_discharge_o = st_r.ss_dis;
    assign readdata_o     = st_r.rdata;
    assign waitrequest_o  = st_r.waitreq;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!rst_n_i);

    sequence inc_edge_s;
        increment_pulse_i && !st_r.inc_prev && !decrement_pulse_i;
    endsequence

    sequence dec_edge_s;
        decrement_pulse_i && !st_r.dec_prev && !increment_pulse_i;
    endsequence

    inc_step_a: assert property (inc_edge_s ##0 (st_r.count != lamp_ctrl_pkg::LEVEL_MAX) |=> // R01
        st_r.count == $past(st_r.count) + lamp_ctrl_pkg::LEVEL_ONE)
        else $error("increment edge did not add one");

    dec_step_a: assert property (dec_edge_s ##0 (st_r.count != lamp_ctrl_pkg::LEVEL_MIN) |=> // R02
        st_r.count == $past(st_r.count) - lamp_ctrl_pkg::LEVEL_ONE)
        else $error("decrement edge did not subtract one");

    mid_preset_a: assert property ((increment_pulse_i && decrement_pulse_i) |=> // R03
        st_r.count == lamp_ctrl_pkg::LEVEL_MID)
        else $error("both inputs high did not preset mid-scale");

    low_power_off_n_switch_a: assert property (!low_power_off_n_i |=> !power_switch_o) // R06
        else $error("switch on during shutdown");

    suspend_pick_a: assert property ((st_r.serial_mode && suspend_config_select_i) |=> // R07
        dac_code_o == $past(st_r.cfg_b))
        else $error("suspend select did not apply second config");

    osc_fast_a: assert property ((sync_at_ref_i && st_r.osc == OSC_FAST_LAST) |=> st_r.osc == 11'h000) // R08
        else $error("fast oscillator period wrong");

    osc_slow_a: assert property ((!sync_at_ref_i && st_r.osc == OSC_FAST_LAST) |=> // R08
        st_r.osc == OSC_FAST_LAST + 11'h001)
        else $error("slow oscillator wrapped early");

    chop_wrap_a: assert property ((floor_level_in_i && st_r.chop == CHOP_LAST) |=> st_r.chop == 20'h00000) // R09
        else $error("chopping period wrong");

    open_tube_a: assert property (open_tube_above_ref_i |=> !power_switch_o) // R10
        else $error("switch on with open tube");

    ss_dis_a: assert property (!low_power_off_n_i |=> ss_discharge_o) // R11
        else $error("soft-start not discharged in shutdown");

    cs_end_a: assert property (cs_above_loop_limit_i |=> !power_switch_o) // R12
        else $error("switch cycle not ended on overcurrent");

    sat_top_a: assert property (inc_edge_s ##0 (st_r.count == lamp_ctrl_pkg::LEVEL_MAX) |=> // R14
        st_r.count == lamp_ctrl_pkg::LEVEL_MAX)
        else $error("counter wrapped above full scale");

    low_power_off_n_keep_a: assert property ((!low_power_off_n_i && !increment_pulse_i && !decrement_pulse_i) |=> // R15
        st_r.count == $past(st_r.count))
        else $error("counter changed in shutdown without pulse");

    sat_bot_a: assert property (dec_edge_s ##0 (st_r.count == lamp_ctrl_pkg::LEVEL_MIN) |=> // R14
        st_r.count == lamp_ctrl_pkg::LEVEL_MIN)
        else $error("counter wrapped below zero");

    dac_follow_a: assert property (!st_r.serial_mode |=> dac_code_o == $past(st_r.count)) // R01
        else $error("dac code does not follow counter");

    cfg_pick_a: assert property ((st_r.serial_mode && !suspend_config_select_i) |=> // R07
        dac_code_o == $past(st_r.cfg_a))
        else $error("suspend low did not apply first config");

    ss_release_a: assert property (low_power_off_n_i |=> !ss_discharge_o) // R11
        else $error("soft-start held low while running");

    chop_gap_a: assert property (!st_r.chop_on |=> !power_switch_o) // R09
        else $error("switch on during chop off-phase");

    chop_idle_a: assert property (!floor_level_in_i |=> (st_r.chop == 20'h00000 && st_r.chop_on)) // R09
        else $error("chopping active outside floor mode");

    sequence lamp_ready_s;
        low_power_off_n_i && !open_tube_above_ref_i && st_r.chop_on && !cs_above_loop_limit_i;
    endsequence

    sw_start_a: assert property (lamp_ready_s ##0 (sync_at_ref_i && st_r.osc == OSC_FAST_LAST) |=> // R08
        power_switch_o)
        else $error("switch did not start at oscillator wrap");

    // ----------------------------------------
    // bus checks
    // ----------------------------------------
    sequence bus_req_s;
        waitrequest_o && (read_i || write_i);
    endsequence

    sequence bus_ack_s;
        !waitrequest_o ##1 waitrequest_o;
    endsequence

    bus_answer_a: assert property (bus_req_s |=> bus_ack_s) // R07
        else $error("bus request not answered after one wait cycle");

    wait_one_a: assert property (!waitrequest_o |=> waitrequest_o) // R07
        else $error("wait request low for more than one cycle");

    rdata_hold_a: assert property (!(waitrequest_o && (read_i || write_i)) |=> // R07
        readdata_o == $past(readdata_o))
        else $error("read data changed without a request");

    cfg_write_a: assert property ((!waitrequest_o && write_i && byteenable_i[0] && // R07
        address_i == lamp_ctrl_pkg::OFS_CFG_A) |=> st_r.cfg_a == $past(writedata_i[4:0]))
        else $error("first config write did not land");

    cfgb_write_a: assert property ((!waitrequest_o && write_i && byteenable_i[0] && // R07
        address_i == lamp_ctrl_pkg::OFS_CFG_B) |=> st_r.cfg_b == $past(writedata_i[4:0]))
        else $error("second config write did not land");

    ctrl_write_a: assert property ((!waitrequest_o && write_i && byteenable_i[0] && // R07
        address_i == lamp_ctrl_pkg::OFS_CTRL) |=> st_r.serial_mode == $past(writedata_i[0]))
        else $error("control write did not land");

endmodule

//--- testbench/pulse_host_model.sv
// host side source of brightness up and down pulses
// assumes a 200 mhz clock; hold times counted in cycles
`timescale 1ns/1ps

module pulse_host_model #(
    parameter int HOLD_CYC = 200
) (
    // clock
    input  wire logic mclk_i,
    // pulse outputs
    output logic      increment_pulse_o,
    output logic      decrement_pulse_o
);
    initial begin
        increment_pulse_o = 1'b0;
        decrement_pulse_o = 1'b0;
    end

    task automatic pulse(input logic up, input logic down);
        increment_pulse_o <= up;
        decrement_pulse_o <= down;
        repeat (HOLD_CYC) @(posedge mclk_i);
        increment_pulse_o <= 1'b0;
        decrement_pulse_o <= 1'b0;
        repeat (HOLD_CYC) @(posedge mclk_i);
    endtask
endmodule

//--- testbench/testbench.sv
// self-checking bench for the lamp brightness control
// assumes the pulse host model and an avalon-mm master here
`timescale 1ns/1ps

module testbench;
    logic        mclk_i  = 1'b0;
    logic        rst_n_i = 1'b0;
    logic        off_n_r = 1'b1;
    logic        susp_r  = 1'b0;
    logic        sync_r  = 1'b1;
    logic        floor_r = 1'b0;
    logic        otp_r   = 1'b0;
    logic        cs_r    = 1'b0;
    logic        cs_en_r = 1'b0;
    logic [3:0]  addr_r  = 4'h0;
    logic        rd_r    = 1'b0;
    logic        wr_r    = 1'b0;
    logic [31:0] wdata_r = 32'h0;
    logic        inc;
    logic        dec;
    logic        sw;
    logic        ssd;
    logic        wreq;
    logic [4:0]  dac;
    logic [31:0] rdata;
    logic [31:0] rv;
    int          num_errors = 0;
    int          n_checks   = 0;
    int          cyc;

    initial begin
        forever #2.5 mclk_i = ~mclk_i;
    end

    // current sense trips one cycle after the switch turns on
    always @(posedge mclk_i) cs_r <= cs_en_r & sw;

    pulse_host_model i_pulse_host_model (
        .mclk_i            (mclk_i),
        .increment_pulse_o (inc),
        .decrement_pulse_o (dec)
    );

    lamp_brightness_updown_ctrl #(.CHOP_CYC(64)) i_lamp_brightness_updown_ctrl (
        .mclk_i                  (mclk_i),
        .rst_n_i                 (rst_n_i),
        .increment_pulse_i       (inc),
        .decrement_pulse_i       (dec),
        .low_power_off_n_i       (off_n_r),
        .suspend_config_select_i (susp_r),
        .sync_at_ref_i           (sync_r),
        .floor_level_in_i        (floor_r),
        .open_tube_above_ref_i   (otp_r),
        .cs_above_loop_limit_i   (cs_r),
        .dac_code_o              (dac),
        .power_switch_o          (sw),
        .ss_discharge_o          (ssd),
        .address_i               (addr_r),
        .read_i                  (rd_r),
        .write_i                 (wr_r),
        .writedata_i             (wdata_r),
        .byteenable_i            (4'hf),
        .readdata_o              (rdata),
        .waitrequest_o           (wreq)
    );

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
        addr_r  <= a;
        wdata_r <= d;
        wr_r    <= w;
        rd_r    <= ~w;
        @(posedge mclk_i);
        while (wreq !== 1'b0) begin
            @(posedge mclk_i);
        end
        q = rdata;
        wr_r <= 1'b0;
        rd_r <= 1'b0;
        @(posedge mclk_i);
    endtask

    task automatic steps(input logic up, input logic down, input int n, input logic [4:0] exp);
        repeat (n) i_pulse_host_model.pulse(up, down);
        check("dac code", dac, exp);
        bus(1'b0, lamp_ctrl_pkg::OFS_STATUS, 32'h0, rv);
        check("status count", rv[4:0], exp);
    endtask

    task automatic wait_sw(input logic lvl);
        while (sw !== lvl) begin
            @(posedge mclk_i);
            cyc++;
        end
    endtask

    task automatic osc(input logic s, input int exp);
        int hi;
        sync_r  <= s;
        cs_en_r <= 1'b1;
        wait_sw(1'b1);
        wait_sw(1'b0);
        wait_sw(1'b1);
        cyc = 0;
        wait_sw(1'b0);
        hi = cyc;
        wait_sw(1'b1);
        check("switch on time", hi, 2);
        check("osc period", cyc, exp);
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    initial begin
        repeat (50000) @(posedge mclk_i);
        num_errors++;
        results();
    end

    initial begin
        repeat (6) @(posedge mclk_i);
        rst_n_i <= 1'b1;
        @(posedge mclk_i);
        check("reset dac", dac, lamp_ctrl_pkg::LEVEL_MID);
        steps(1'b1, 1'b0, 3, 5'h13);
        steps(1'b0, 1'b1, 2, 5'h11);
        steps(1'b1, 1'b1, 1, 5'h10);
        steps(1'b1, 1'b0, 16, 5'h1f);
        steps(1'b1, 1'b0, 1, 5'h1f);
        steps(1'b0, 1'b1, 32, 5'h00);
        $display("counter test done");
        osc(1'b1, lamp_ctrl_pkg::OSC_FAST_CYC);
        osc(1'b0, lamp_ctrl_pkg::OSC_SLOW_CYC);
        cs_en_r <= 1'b0;
        wait_sw(1'b1);
        otp_r <= 1'b1;
        repeat (1500) @(posedge mclk_i);
        check("open tube switch", sw, 1'b0);
        check("open tube discharge", ssd, 1'b0);
        otp_r <= 1'b0;
        wait_sw(1'b1);
        off_n_r <= 1'b0;
        repeat (3) @(posedge mclk_i);
        check("off switch", sw, 1'b0);
        check("off discharge", ssd, 1'b1);
        steps(1'b1, 1'b0, 1, 5'h01);
        off_n_r <= 1'b1;
        repeat (3) @(posedge mclk_i);
        check("on discharge", ssd, 1'b0);
        $display("switch test done");
        wait_sw(1'b1);
        floor_r <= 1'b1;
        cyc = 0;
        wait_sw(1'b0);
        check("chop off within period", cyc <= 64, 1'b1);
        bus(1'b0, lamp_ctrl_pkg::OFS_STATUS, 32'h0, rv);
        check("chop mode", rv[lamp_ctrl_pkg::STAT_CHOP_BIT], 1'b1);
        repeat (64) @(posedge mclk_i);
        check("chop held off", sw, 1'b0);
        floor_r <= 1'b0;
        bus(1'b1, lamp_ctrl_pkg::OFS_CFG_A, 32'h05, rv);
        bus(1'b1, lamp_ctrl_pkg::OFS_CFG_B, 32'h1a, rv);
        bus(1'b1, lamp_ctrl_pkg::OFS_CTRL, 32'h1, rv);
        repeat (3) @(posedge mclk_i);
        check("config a", dac, 5'h05);
        susp_r <= 1'b1;
        repeat (3) @(posedge mclk_i);
        check("config b", dac, 5'h1a);
        bus(1'b0, 4'h2, 32'h0, rv);
        check("unmapped", rv, 32'h0);
        $display("register test done");
        results();
    end
endmodule
